// ==== fbc_insn_execute.sv ====
// Decode and execute of load, exchange, pointer, flag, jump, call, return and bit-branch instructions.
// Assumes a combinational program ROM and data RAM on clk_sys; RAM writes land at the clock edge.
//
// Behaviour
// - Load memory nibble into accumulator, update zero.
// - Swap memory, XOR pointer high, zero from result.
// - Plain swap; zero from pointer high nibble.
// - Swap memory, increment pointer low, update zero.
// - Swap memory, decrement pointer low, update zero.
// - Table read from ROM into accumulator and E.
// - Load pointer low with zero high; load high.
// - Increment or decrement pointer low, update zero.
// - Swap accumulator with pointer high, flags kept.
// - Swap with working nibbles in one cycle.
// - Set or clear user flag; clear updates zero.
// - Two-byte jump within current bank.
// - Page jump to E and accumulator.
// - Page zero call pushes return address.
// - Two-byte call into bank zero.
// - Subroutine return pops program counter.
// - Interrupt return restores carry and zero.
// - Bank prefix toggles bank and selects pseudo port.
// - Set bank applies to immediately following jump.
// - Branch on accumulator bit set or clear.
// - Branch on memory bit set.
//
// The strobed register port and the placing of the registers were decided locally.
`include "fbc_defines.svh"

module fbc_insn_execute
  import fbc_pkg::*;
#(
  parameter int STACK_DEPTH = `FBC_STACK_DEPTH
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Program ROM
  output logic [`FBC_PC_W-1:0]         romAddr,
  input  wire logic [7:0]              romData,
  // Data RAM
  output fbc_pkg::fbc_ram_req_t        ramReq,
  input  wire logic [3:0]              ramRdata,
  // Register port
  input  wire fbc_pkg::fbc_bus_req_t   busReq,
  output logic [`FBC_BUS_DW-1:0]       busRdata,
  // Port block
  output logic                         pseudoIoSel
);
  import fbc_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fbc_state_t                 state_r, state_nxt;
  logic [`FBC_PC_W-1:0]       pc_r, pc_nxt, romAddr_r, romAddr_nxt;
  logic [`FBC_PC_W-1:0]       stack_r [STACK_DEPTH];
  logic [SPW-1:0]             sp_r, sp_nxt;
  logic                       push, pop;
  logic [`FBC_PC_W-1:0]       pushVal;
  logic [3:0]                 acc_r, acc_nxt, eReg_r, eReg_nxt;
  logic [3:0]                 ptrHigh_r, ptrHigh_nxt, ptrLow_r, ptrLow_nxt;
  logic                       zeroFlag_r, zeroFlag_nxt, carryFlag_r, carryFlag_nxt;
  logic                       savedCarry_r, savedZero_r;
  logic [15:0]                userFlags_r, userFlags_nxt;
  logic [3:0]                 workAcc_r [4];
  logic [3:0]                 workHigh_r [2];
  logic [3:0]                 workLow_r [2];
  logic [7:0]                 opcode_r, opcode_nxt;
  logic [1:0]                 bankPend_r, bankPend_nxt;
  logic                       bankValid_r, bankValid_nxt, pseudo_r, pseudo_nxt;
  fbc_ram_req_t               ramReq_r, ramReq_nxt;
  logic [`FBC_BUS_DW-1:0]     ctrl_r, busRdata_r;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic isTwoByte(input logic [7:0] op);
    isTwoByte = (op[7:4] == `OPN_JUMP_SB && op[3]) || (op[7:4] == `OPN_SWAP_XOR && op[3]) ||
                op[7:4] == `OPN_BR_POS || op[7:4] == `OPN_BR_NEG ||
                op[7:4] == `OPN_BR_FLAG_P || op[7:4] == `OPN_BR_FLAG_N;
  endfunction : isTwoByte

  wire        running    = ctrl_r[`FBC_CTRL_RUN];
  wire [7:0]  op         = romData;
  wire [3:0]  opHi       = op[7:4];
  wire [3:0]  opLo       = op[3:0];
  wire        twoByte    = isTwoByte(op);
  wire        isSwapXor  = opHi == `OPN_SWAP_XOR && !op[3];
  wire        isSwapInc  = op == `OP_SWAP_INC;
  wire        isSwapDec  = op == `OP_SWAP_DEC;
  wire        isWorkAcc  = opHi == `OPN_WORK_HI && op[3:2] == `OPL_WORK_ACC;
  wire        isWorkHigh = opHi == `OPN_WORK_HI && op[2:0] == `OPL_WORK_PTR;
  wire        isWorkLow  = opHi == `OPN_WORK_LO && op[2:0] == `OPL_WORK_PTR;
  wire        isBankSet  = opHi == `OPN_JUMP_SB && op[3:2] == `OPL_BANK_SET;
  wire [3:0]  incLow     = ptrLow_r + 4'h1;
  wire [3:0]  decLow     = ptrLow_r - 4'h1;
  wire [3:0]  xorHigh    = ptrHigh_r ^ {1'b0, opcode_r[2:0]};
  wire [3:0]  grpCleared = userFlags_r[{opLo[3:2], 2'b00} +: 4] & ~(4'h1 << opLo[1:0]);
  wire [`FBC_PC_W-1:0] pcInc = pc_r + `FBC_PC_W'(1);
  wire [`FBC_PC_W-1:0] stackTop = stack_r[sp_r - SPW'(1)];
  wire [`FBC_PC_W-1:0] pageTarget = {pc_r[`FBC_PC_W-1:8], op};
  // Branch form and bit selector sit in the opcode byte; the operand byte is the whole in-page target.
  wire [1:0]  brSel      = opcode_r[1:0];
  wire        brAccHit   = opcode_r[7:4] == `OPN_BR_POS ? acc_r[brSel] : !acc_r[brSel];
  wire        brAccForm  = opcode_r[3:2] == `OPL_BR_ACC &&
                           (opcode_r[7:4] == `OPN_BR_POS || opcode_r[7:4] == `OPN_BR_NEG);
  wire        brMemForm  = opcode_r[3:2] == `OPL_BR_MEM && opcode_r[7:4] == `OPN_BR_POS;

  // --------------------------------------------------------------------------
  // Register port decode
  // --------------------------------------------------------------------------
  wire        selCtrl    = busReq.addr == `FBC_REG_CTRL;
  wire        selStatus  = busReq.addr == `FBC_REG_STATUS;
  wire        selPc      = busReq.addr == `FBC_REG_PC;
  wire        selSaved   = busReq.addr == `FBC_REG_SAVED;
  wire [`FBC_BUS_DW-1:0] readMux =
      selCtrl   ? ctrl_r :
      selStatus ? {2'b00, state_r, 2'b00, zeroFlag_r, carryFlag_r, ptrHigh_r, acc_r} :
      selPc     ? {3'b000, pc_r} :
      selSaved  ? {14'h0000, savedCarry_r, savedZero_r} : 16'h0000;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    pc_nxt        = pc_r;
    sp_nxt        = sp_r;
    push          = 1'b0;
    pop           = 1'b0;
    pushVal       = pcInc;
    acc_nxt       = acc_r;
    eReg_nxt      = eReg_r;
    ptrHigh_nxt   = ptrHigh_r;
    ptrLow_nxt    = ptrLow_r;
    zeroFlag_nxt  = zeroFlag_r;
    carryFlag_nxt = carryFlag_r;
    userFlags_nxt = userFlags_r;
    opcode_nxt    = opcode_r;
    bankPend_nxt  = bankPend_r;
    bankValid_nxt = bankValid_r;
    pseudo_nxt    = pseudo_r;
    ramReq_nxt    = '{we: 1'b0, addr: {ptrHigh_r, ptrLow_r}, wdata: acc_r};
    unique case (state_r)
      ST_FETCH: begin
        if (running) begin
          pc_nxt        = pcInc;
          opcode_nxt    = op;
          // A prefix only lives for the instruction right after it.
          bankValid_nxt = 1'b0;
          pseudo_nxt    = 1'b0;
          if (twoByte) begin
            state_nxt     = ST_OPERAND;
            bankValid_nxt = bankValid_r;
          end else if (op == `OP_LOAD_MEM) begin
            acc_nxt      = ramRdata;
            zeroFlag_nxt = ramRdata == 4'h0;
          end else if (isSwapXor || isSwapInc || isSwapDec) begin
            acc_nxt          = ramRdata;
            ramReq_nxt.we    = 1'b1;
            state_nxt        = ST_SECOND;
          end else if (op == `OP_TABLE_READ) begin
            state_nxt = ST_TABLE;
          end else if (opHi == `OPN_ZERO_HIGH) begin
            ptrHigh_nxt = 4'h0;
            ptrLow_nxt  = opLo;
          end else if (opHi == `OPN_HIGH_IMM) begin
            ptrHigh_nxt = opLo;
          end else if (op == `OP_INC_LOW || op == `OP_DEC_LOW) begin
            ptrLow_nxt   = op[0] ? decLow : incLow;
            zeroFlag_nxt = (op[0] ? decLow : incLow) == 4'h0;
          end else if (op == `OP_ACC_TO_LOW) begin
            ptrLow_nxt = acc_r;
          end else if (op == `OP_LOW_TO_ACC) begin
            acc_nxt      = ptrLow_r;
            zeroFlag_nxt = ptrLow_r == 4'h0;
          end else if (op == `OP_SWAP_HIGH) begin
            acc_nxt     = ptrHigh_r;
            ptrHigh_nxt = acc_r;
          end else if (isWorkAcc) begin
            acc_nxt = workAcc_r[op[1:0]];
          end else if (isWorkHigh) begin
            ptrHigh_nxt = workHigh_r[op[3]];
          end else if (isWorkLow) begin
            ptrLow_nxt = workLow_r[op[3]];
          end else if (opHi == `OPN_FLAG_SET) begin
            userFlags_nxt[opLo] = 1'b1;
          end else if (opHi == `OPN_FLAG_CLR) begin
            userFlags_nxt[opLo] = 1'b0;
            zeroFlag_nxt        = grpCleared == 4'h0;
          end else if (op == `OP_PAGE_JUMP) begin
            pc_nxt = {pc_r[`FBC_PC_W-1:8], eReg_r, acc_r};
          end else if (opHi == `OPN_ZPAGE_CALL) begin
            push   = 1'b1;
            sp_nxt = sp_r + SPW'(1);
            pc_nxt = {{(`FBC_PC_W-6){1'b0}}, opLo, 2'b00};
          end else if (op == `OP_SUB_RET || op == `OP_INT_RET) begin
            pop    = 1'b1;
            pc_nxt = stackTop;
            if (op == `OP_INT_RET) begin
              carryFlag_nxt = savedCarry_r;
              zeroFlag_nxt  = savedZero_r;
            end
          end else if (op == `OP_BANK_PREFIX) begin
            // toggle bank and pick pseudo port
            bankPend_nxt  = {pc_r[`FBC_PC_W-1], ~pc_r[`FBC_PC_W-2]};
            bankValid_nxt = 1'b1;
            pseudo_nxt    = 1'b1;
          end else if (isBankSet) begin
            bankPend_nxt  = op[1:0];
            bankValid_nxt = 1'b1;
          end
        end
      end
      ST_OPERAND: begin
        state_nxt     = ST_FETCH;
        bankValid_nxt = 1'b0;
        pc_nxt        = pcInc;
        if (opcode_r[7:4] == `OPN_JUMP_SB) begin
          pc_nxt = {bankValid_r ? bankPend_r : pc_r[`FBC_PC_W-1 -: 2], opcode_r[2:0], op};
        end else if (opcode_r[7:4] == `OPN_SWAP_XOR) begin
          push   = 1'b1;
          sp_nxt = sp_r + SPW'(1);
          pc_nxt = {2'b00, opcode_r[2:0], op};
        end else if (brAccForm && brAccHit) begin
          pc_nxt = pageTarget;
        end else if (brMemForm && ramRdata[brSel]) begin
          pc_nxt = pageTarget;
        end
      end
      ST_SECOND: begin
        state_nxt = ST_FETCH;
        if (opcode_r == `OP_SWAP_INC) begin
          ptrLow_nxt   = incLow;
          zeroFlag_nxt = incLow == 4'h0;
        end else if (opcode_r == `OP_SWAP_DEC) begin
          ptrLow_nxt   = decLow;
          zeroFlag_nxt = decLow == 4'h0;
        end else if (opcode_r == `OP_SWAP_MEM) begin
          zeroFlag_nxt = ptrHigh_r == 4'h0;
        end else begin
          ptrHigh_nxt  = xorHigh;
          zeroFlag_nxt = xorHigh == 4'h0;
        end
      end
      ST_TABLE: begin
        // table byte into accumulator and E
        state_nxt = ST_FETCH;
        acc_nxt   = romData[7:4];
        eReg_nxt  = romData[3:0];
      end
    endcase
    if (pop) begin
      sp_nxt = sp_r - SPW'(1);
    end
    // The address register carries the next pointer, so the RAM answers for the pointer of each cycle.
    ramReq_nxt.addr = {ptrHigh_nxt, ptrLow_nxt};
  end

  // table address replaces low eight bits
  assign romAddr_nxt = state_nxt == ST_TABLE ? {pc_r[`FBC_PC_W-1:8], eReg_r, acc_r} : pc_nxt;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r     <= ST_FETCH;
      pc_r        <= '0;
      romAddr_r   <= '0;
      sp_r        <= '0;
      acc_r       <= 4'h0;
      eReg_r      <= 4'h0;
      ptrHigh_r   <= 4'h0;
      ptrLow_r    <= 4'h0;
      zeroFlag_r  <= 1'b0;
      carryFlag_r <= 1'b0;
      userFlags_r <= 16'h0000;
      opcode_r    <= 8'h00;
      bankPend_r  <= 2'b00;
      bankValid_r <= 1'b0;
      pseudo_r    <= 1'b0;
      ramReq_r    <= '0;
    end else begin
      state_r     <= state_nxt;
      pc_r        <= pc_nxt;
      romAddr_r   <= romAddr_nxt;
      sp_r        <= sp_nxt;
      acc_r       <= acc_nxt;
      eReg_r      <= eReg_nxt;
      ptrHigh_r   <= ptrHigh_nxt;
      ptrLow_r    <= ptrLow_nxt;
      zeroFlag_r  <= zeroFlag_nxt;
      carryFlag_r <= carryFlag_nxt;
      userFlags_r <= userFlags_nxt;
      opcode_r    <= opcode_nxt;
      bankPend_r  <= bankPend_nxt;
      bankValid_r <= bankValid_nxt;
      pseudo_r    <= pseudo_nxt;
      ramReq_r    <= ramReq_nxt;
    end
  end

  // The stack wraps silently; depth overflow is the program's problem.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      stack_r[sp_r] <= pushVal;
    end
  end

  // Working nibbles take the other side of each one-cycle swap.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      workAcc_r  <= '{default: 4'h0};
      workHigh_r <= '{default: 4'h0};
      workLow_r  <= '{default: 4'h0};
    end else if (state_r == ST_FETCH && running) begin
      if (isWorkAcc) begin
        workAcc_r[op[1:0]] <= acc_r;
      end
      if (isWorkHigh) begin
        workHigh_r[op[3]] <= ptrHigh_r;
      end
      if (isWorkLow) begin
        workLow_r[op[3]] <= ptrLow_r;
      end
    end
  end

  // Saved flags come from the interrupt entry logic through the register port.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r       <= `FBC_CTRL_RST;
      savedCarry_r <= 1'b0;
      savedZero_r  <= 1'b0;
      busRdata_r   <= '0;
    end else begin
      if (busReq.wr && selCtrl) begin
        ctrl_r <= busReq.wdata;
      end
      if (busReq.wr && selSaved) begin
        savedCarry_r <= busReq.wdata[1];
        savedZero_r  <= busReq.wdata[0];
      end
      busRdata_r <= busReq.rd ? readMux : '0;
    end
  end

  assign romAddr     = romAddr_r;
  assign ramReq      = ramReq_r;
  assign busRdata    = busRdata_r;
  assign pseudoIoSel = pseudo_r;

endmodule : fbc_insn_execute

// ==== fbc_defines.svh ====
// Constants for the four-bit core instruction decode and execute block.
// Assumes it is included by its bare name from the package and the core.
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------------
`define FBC_PC_W        13
`define FBC_STACK_DEPTH 8
`define FBC_BUS_AW      8
`define FBC_BUS_DW      16

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define FBC_REG_CTRL    8'h00
`define FBC_REG_STATUS  8'h04
`define FBC_REG_PC      8'h08
`define FBC_REG_SAVED   8'h0c
`define FBC_CTRL_RUN    0
`define FBC_CTRL_RST    16'h0001

// ----------------------------------------------------------------------------
// Opcodes, full bytes
// ----------------------------------------------------------------------------
`define OP_LOAD_MEM     8'hc1
`define OP_SWAP_MEM     8'ha0
`define OP_SWAP_INC     8'hfe
`define OP_SWAP_DEC     8'hff
`define OP_TABLE_READ   8'h63
`define OP_INC_LOW      8'hee
`define OP_DEC_LOW      8'hef
`define OP_ACC_TO_LOW   8'hf7
`define OP_LOW_TO_ACC   8'he9
`define OP_SWAP_HIGH    8'h23
`define OP_PAGE_JUMP    8'hfa
`define OP_SUB_RET      8'h62
`define OP_INT_RET      8'h22
`define OP_BANK_PREFIX  8'hfd

// ----------------------------------------------------------------------------
// Opcodes, upper nibbles and sub-patterns
// ----------------------------------------------------------------------------
`define OPN_SWAP_XOR    4'ha
`define OPN_ZERO_HIGH   4'h8
`define OPN_HIGH_IMM    4'h4
`define OPN_FLAG_SET    4'h5
`define OPN_FLAG_CLR    4'h1
`define OPN_JUMP_SB     4'h6
`define OPN_ZPAGE_CALL  4'hb
`define OPN_BR_POS      4'h7
`define OPN_BR_NEG      4'h3
`define OPN_BR_FLAG_P   4'hd
`define OPN_BR_FLAG_N   4'h9
`define OPN_WORK_HI     4'hf
`define OPN_WORK_LO     4'he
`define OPL_WORK_ACC    2'b00
`define OPL_WORK_PTR    3'b100
`define OPL_BANK_SET    2'b01
`define OPL_BR_ACC      2'b00
`define OPL_BR_MEM      2'b01

`endif

// ==== fbc_pkg.sv ====
// Types shared by the four-bit core decode and execute block.
// Assumes fbc_defines.svh sits in the same folder.
`include "fbc_defines.svh"

package fbc_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FETCH   = 2'b00,
    ST_OPERAND = 2'b01,
    ST_SECOND  = 2'b10,
    ST_TABLE   = 2'b11
  } fbc_state_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [3:0] wdata;
  } fbc_ram_req_t;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`FBC_BUS_AW-1:0] addr;
    logic [`FBC_BUS_DW-1:0] wdata;
  } fbc_bus_req_t;

endpackage : fbc_pkg

// ==== fbc_insn_properties.sv ====
// Concurrent checks on the ports of the four-bit core decode and execute block.
// Assumes it is bound to fbc_insn_execute from the bench top, one clock domain.
`include "fbc_defines.svh"

module fbc_insn_properties (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset,
  // Program ROM
  input wire logic [`FBC_PC_W-1:0]    romAddr,
  input wire logic [7:0]              romData,
  // Data RAM
  input wire fbc_pkg::fbc_ram_req_t   ramReq,
  input wire logic [3:0]              ramRdata,
  // Register port
  input wire fbc_pkg::fbc_bus_req_t   busReq,
  input wire logic [`FBC_BUS_DW-1:0]  busRdata,
  // Port block
  input wire logic                    pseudoIoSel
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbc_pkg::*;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // --------------------------------------------------------------------------
  // Reset, memory strobes and prefix
  // --------------------------------------------------------------------------
  chk_reset_outs: assert property ($fell(reset) |-> romAddr == '0 && !ramReq.we && busRdata == '0 && !pseudoIoSel)
    else $error("outputs not idle after reset");
  chk_we_pulse: assert property (ramReq.we |=> !ramReq.we)
    else $error("ram write strobe longer than one cycle");
  chk_we_cause: assert property ($rose(ramReq.we) |-> $past(romData) inside {[8'ha0:8'ha7], 8'hfe, 8'hff})
    else $error("ram write without a swap opcode");
  chk_prefix_sel: assert property ($rose(pseudoIoSel) |-> $past(romData) == 8'hfd)
    else $error("pseudo port select without bank prefix");

  // --------------------------------------------------------------------------
  // Register port answers
  // --------------------------------------------------------------------------
  chk_rdata_idle: assert property (busRdata != '0 |-> $past(busReq.rd))
    else $error("read data without a read");
  chk_unmapped_rd: assert property (busReq.rd && !(busReq.addr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |=> busRdata == '0)
    else $error("unmapped read not zero");
  chk_pc_upper: assert property (busReq.rd && busReq.addr == 8'h08 |=> busRdata[15:13] == 3'b000)
    else $error("program counter read has upper bits set");
  chk_status_pad: assert property (busReq.rd && busReq.addr == 8'h04 |=> busRdata[15:14] == 2'b00 && busRdata[11:10] == 2'b00)
    else $error("status read has padding bits set");
  chk_saved_rw: assert property (busReq.wr && busReq.addr == 8'h0c ##1 busReq.rd && busReq.addr == 8'h0c
                                 |=> busRdata == ($past(busReq.wdata, 2) & 16'h0003))
    else $error("saved flags not read back");
endmodule : fbc_insn_properties

// ==== fbc_mem_model.sv ====
// Program ROM and data RAM that sit beside the decode and execute block.
// Assumes the bench fills both arrays while the block is held in reset.
`include "fbc_defines.svh"

module fbc_mem_model (
  // Clock
  input wire logic                   clk_sys,
  // Program ROM
  input wire logic [`FBC_PC_W-1:0]   romAddr,
  output logic [7:0]                 romData,
  // Data RAM
  input wire fbc_pkg::fbc_ram_req_t  ramReq,
  output logic [3:0]                 ramRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbc_pkg::*;

  logic [7:0] rom [0:(1 << `FBC_PC_W) - 1];
  logic [3:0] ram [0:255];

  assign romData = rom[romAddr];
  assign ramRdata = ram[ramReq.addr];

  // Writes land at the edge, so the swap sees the old nibble first.
  always @(posedge clk_sys) begin
    if (ramReq.we) begin
      ram[ramReq.addr] <= ramReq.wdata;
    end
  end
endmodule : fbc_mem_model

// ==== tb_top.sv ====
// Self-checking bench for the decode and execute block: short programs, then register reads.
// Assumes the ROM and RAM model and the property checker are compiled beside it.
`include "fbc_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fbc_pkg::*;

  typedef struct {logic [47:0] prog; logic [1:0] sv; logic [15:0] st; logic [15:0] pc; logic [7:0] ra; logic [3:0] rv;} fbc_row_t;

  logic                    clk_sys = 1'b0;
  logic                    reset = 1'b1;
  logic [`FBC_PC_W-1:0]    romAddr;
  logic [7:0]              romData;
  fbc_ram_req_t            ramReq;
  logic [3:0]              ramRdata;
  fbc_bus_req_t            busReq = '0;
  logic [`FBC_BUS_DW-1:0]  busRdata;
  logic                    pseudoIoSel;
  int                      badCount = 0;
  int                      checks = 0;
  logic [15:0]             v;

  // Program bytes first, then saved flags, status, halted pc and one RAM nibble to inspect.
  fbc_row_t rows [29] = '{
    '{48'h83c1_0000_0000, 2'h0, 16'h0009, 16'h0010, 8'h03, 4'h9},
    '{48'h81c1_45a3_0000, 2'h0, 16'h006e, 16'h0010, 8'h51, 4'hb},
    '{48'h45a5_0000_0000, 2'h0, 16'h020f, 16'h0010, 8'h50, 4'h0},
    '{48'h43a0_0000_0000, 2'h0, 16'h0039, 16'h0010, 8'h30, 4'h0},
    '{48'ha000_0000_0000, 2'h0, 16'h020a, 16'h0010, 8'h00, 4'h0},
    '{48'h8ffe_e900_0000, 2'h0, 16'h0200, 16'h0010, 8'h0f, 4'h0},
    '{48'h80ff_e900_0000, 2'h0, 16'h000f, 16'h0010, 8'h00, 4'h0},
    '{48'h6363_fa00_0000, 2'h0, 16'h0005, 16'h00c5, 8'hff, 4'ha},
    '{48'h4c87_e900_0000, 2'h0, 16'h0007, 16'h0010, 8'hff, 4'ha},
    '{48'h8fee_e900_0000, 2'h0, 16'h0200, 16'h0010, 8'hff, 4'ha},
    '{48'h80ef_e900_0000, 2'h0, 16'h000f, 16'h0010, 8'hff, 4'ha},
    '{48'h87c1_f7e9_0000, 2'h0, 16'h000d, 16'h0010, 8'hff, 4'ha},
    '{48'h8ac1_4a23_0000, 2'h0, 16'h020a, 16'h0010, 8'hff, 4'ha},
    '{48'h87c1_f2e9_f200, 2'h0, 16'h000d, 16'h0010, 8'hff, 4'ha},
    '{48'h4bfc_4cf4_fc23, 2'h0, 16'h000b, 16'h0010, 8'hff, 4'ha},
    '{48'h89ec_83e4_ece9, 2'h0, 16'h0009, 16'h0010, 8'hff, 4'ha},
    '{48'h5312_0000_0000, 2'h0, 16'h0000, 16'h0010, 8'hff, 4'ha},
    '{48'h5313_0000_0000, 2'h0, 16'h0200, 16'h0010, 8'hff, 4'ha},
    '{48'h6820_0000_0000, 2'h0, 16'h0000, 16'h0020, 8'hff, 4'ha},
    '{48'hb500_0000_0000, 2'h0, 16'h0000, 16'h0014, 8'hff, 4'ha},
    '{48'ha830_0000_0000, 2'h0, 16'h0070, 16'h0010, 8'hff, 4'ha},
    '{48'ha838_0000_0000, 2'h3, 16'h0300, 16'h0010, 8'hff, 4'ha},
    '{48'hfd68_2000_0000, 2'h0, 16'h0000, 16'h0820, 8'hff, 4'ha},
    '{48'h6668_2000_0000, 2'h0, 16'h0000, 16'h1020, 8'hff, 4'ha},
    '{48'h6600_6820_0000, 2'h0, 16'h0000, 16'h0020, 8'hff, 4'ha},
    '{48'h87c1_3120_0000, 2'h0, 16'h000d, 16'h0020, 8'hff, 4'ha},
    '{48'h8776_2000_0000, 2'h0, 16'h0000, 16'h0020, 8'hff, 4'ha},
    '{48'h87c1_7220_0000, 2'h0, 16'h000d, 16'h0020, 8'hff, 4'ha},
    '{48'h8775_2000_0000, 2'h0, 16'h0000, 16'h0010, 8'hff, 4'ha}
  };

  always #25 clk_sys = ~clk_sys;

  fbc_insn_execute dut (.clk_sys(clk_sys), .reset(reset), .romAddr(romAddr), .romData(romData), .ramReq(ramReq),
                        .ramRdata(ramRdata), .busReq(busReq), .busRdata(busRdata), .pseudoIoSel(pseudoIoSel));
  fbc_mem_model mem (.clk_sys(clk_sys), .romAddr(romAddr), .romData(romData), .ramReq(ramReq), .ramRdata(ramRdata));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys) busReq <= '0;
  endtask : idle

  // A write leaves the strobe up; the caller follows it with a read or idle cycles.
  task automatic busWr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask : busWr

  task automatic busRd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    busReq <= '0;
    #1;
    d = busRdata;
  endtask : busRd

  // Each row starts from reset; the RAM holds a pattern mixing both pointer nibbles.
  task automatic runRow(input fbc_row_t r);
    logic [15:0] d;
    @(posedge clk_sys) reset <= 1'b1;
    @(posedge clk_sys);
    for (int k = 0; k < 6; k++) mem.rom[k] = r.prog[47 - 8 * k -: 8];
    for (int a = 0; a < 256; a++) mem.ram[a] = a[3:0] ^ a[7:4] ^ 4'ha;
    @(posedge clk_sys) reset <= 1'b0;
    busWr(8'h0c, {14'h0000, r.sv});
    idle(60);
    busWr(8'h00, 16'h0000);
    idle(4);
    busRd(8'h08, d);
    check("pc", d, r.pc);
    busRd(8'h04, d);
    check("status", d, r.st);
    check("ram", {12'h000, mem.ram[r.ra]}, {12'h000, r.rv});
  endtask : runRow

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    for (int i = 0; i < (1 << `FBC_PC_W); i++) mem.rom[i] = 8'h00;
    // Self loops catch each program; a routine sits at 0x30 and 0x3c, table data at 0x36.
    {mem.rom[16], mem.rom[17], mem.rom[20], mem.rom[21]} = 32'h6810_6814;
    {mem.rom[32], mem.rom[33], mem.rom[197], mem.rom[198]} = 32'h6820_68c5;
    {mem.rom[48], mem.rom[49], mem.rom[54], mem.rom[60]} = 32'h4762_5c22;
    {mem.rom[2080], mem.rom[2081], mem.rom[4128], mem.rom[4129]} = 32'h6820_6820;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    busRd(8'h00, v);
    check("ctrl", v, 16'h0001);
    busRd(8'h0c, v);
    check("saved", v, 16'h0000);
    busWr(8'h10, 16'hffff);
    busRd(8'h0c, v);
    check("saved", v, 16'h0000);
    busRd(8'h10, v);
    check("unmapped", v, 16'h0000);
    busWr(8'h0c, 16'hffff);
    busRd(8'h0c, v);
    check("saved", v, 16'h0003);
    foreach (rows[i]) runRow(rows[i]);
    end_of_test;
  end
endmodule : tb_top

bind fbc_insn_execute fbc_insn_properties u_props (.clk_sys(clk_sys), .reset(reset), .romAddr(romAddr),
  .romData(romData), .ramReq(ramReq), .ramRdata(ramRdata), .busReq(busReq), .busRdata(busRdata),
  .pseudoIoSel(pseudoIoSel));
